// file: rtl/lcdrpd_pkg.sv
// Package with defaults, command codes and timing counts for the reset and power-down block
package lcdrpd_pkg;
    localparam logic [7:0] CMD_DISP_OFF      = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON       = 8'hAF;
    localparam logic [7:0] CMD_ALLON_OFF     = 8'hA4;
    localparam logic [7:0] CMD_ALLON_ON      = 8'hA5;
    localparam logic [7:0] CMD_NORM_DISP     = 8'hA6;
    localparam logic [7:0] CMD_REV_DISP      = 8'hA7;
    localparam logic [7:0] CMD_SEG_NORM      = 8'hA0;
    localparam logic [7:0] CMD_SEG_REV       = 8'hA1;
    localparam logic [7:0] CMD_SW_RESET      = 8'hE2;
    localparam logic [7:0] CMD_RMW_ON        = 8'hE0;
    localparam logic [7:0] CMD_RMW_END       = 8'hEE;
    localparam logic [7:0] CMD_STATIC_OFF    = 8'hAC;
    localparam logic [7:0] CMD_STATIC_ON     = 8'hAD;
    localparam logic [7:0] CMD_COM_NORM      = 8'hC0;
    localparam logic [7:0] CMD_COM_REV       = 8'hC8;
    localparam logic [7:0] CMD_CONTRAST_MODE = 8'h81;
    localparam logic [7:0] CMD_TEST_MODE     = 8'hF0;
    localparam logic [3:0] CMD_PWR_HI        = 4'h2;
    localparam logic [3:0] CMD_RATIO_HI      = 4'h2;
    localparam logic [1:0] CMD_START_HI      = 2'h1;
    localparam logic [3:0] CMD_PAGE_HI       = 4'hB;
    localparam logic [3:0] CMD_COLH_HI       = 4'h1;
    localparam logic [3:0] CMD_COLL_HI       = 4'h0;
    localparam int         PWR_HI_POS        = 3;
    localparam logic [5:0] CONTRAST_RST      = 6'h20;
    localparam logic [2:0] PWR_RST           = 3'h0;
    localparam logic [1:0] STATIC_REG_RST    = 2'h0;
    localparam logic [5:0] START_RST         = 6'h00;
    localparam logic [7:0] COL_RST           = 8'h00;
    localparam logic [3:0] PAGE_RST          = 4'h0;
    localparam int         RESET_BUSY_NS     = 1000;
    localparam int         CLK_PERIOD_PS     = 5000;
    localparam int         RESET_BUSY_CYC    = (RESET_BUSY_NS * 1000) / CLK_PERIOD_PS;
    localparam int         LINE_DIV_CYC      = 64;
    localparam int         LINES_PER_FRAME   = 65;
endpackage

// file: rtl/lcdrpd_cmd_if.sv
// Interface carrying decoded commands from the host port to the control core
`timescale 1ns/1ps
interface lcdrpd_cmd_if;
    logic       valid;
    logic [7:0] data;
    modport src (output valid, output data);
    modport dst (input valid, input data);
endinterface

// file: rtl/lcdrpd_serial_rx.sv
// Serial host port receiver: shifts bits MSB first and hands bytes on
`timescale 1ns/1ps
module lcdrpd_serial_rx (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   hw_clear_i,
    input  wire logic   sclk_i,
    input  wire logic   sdata_i,
    input  wire logic   cs_n_i,
    lcdrpd_cmd_if.src   cmd
);
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic       sclk_prev_q;
    logic       valid_q;
    logic [7:0] data_q;

    assign cmd.valid = valid_q;
    assign cmd.data  = data_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q     <= 8'h00;
            cnt_q       <= 3'h0;
            sclk_prev_q <= 1'b1;
            valid_q     <= 1'b0;
            data_q      <= 8'h00;
        end else begin
            sclk_prev_q <= sclk_i;
            valid_q     <= 1'b0;
            if (hw_clear_i || cs_n_i) begin
                // Partial bytes are dropped
                shift_q <= 8'h00;
                cnt_q   <= 3'h0;
            end else if (sclk_i && !sclk_prev_q) begin
                shift_q <= {shift_q[6:0], sdata_i};
                cnt_q   <= cnt_q + 3'h1;
                if (cnt_q == 3'h7) begin
                    valid_q <= 1'b1;
                    data_q  <= {shift_q[6:0], sdata_i};
                end
            end
        end
    end

    hw_clear_empties_a: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_clear_i |=> (cnt_q == 3'h0) && (shift_q == 8'h00))
        else $error("shift register not cleared by hardware reset");
endmodule

// file: rtl/lcdrpd_top.sv
// Reset, software reset and power-down control core of the LCD driver
`timescale 1ns/1ps
module lcdrpd_top
    import lcdrpd_pkg::*;
#(
    parameter bit RES_CONNECTED_VARIANT = 1'b0,
    parameter int RESET_BUSY_CYCLES     = RESET_BUSY_CYC
) (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic       HW_RESET_N_I,
    input  wire logic       DRIVE_STRENGTH_SEL_I,
    input  wire logic       SCLK_I,
    input  wire logic       SDATA_I,
    input  wire logic       CS_N_I,
    input  wire logic       DB_READ_I,
    output logic            STATUS_BUSY_O,
    output logic            STATUS_RESET_O,
    output logic            STATUS_SEG_NORMAL_O,
    output logic            STATUS_DISP_OFF_O,
    output logic            DB_OE_O,
    output logic            DISPLAY_ON_O,
    output logic            REVERSE_DISP_O,
    output logic            ALL_ON_O,
    output logic            POWER_SAVE_O,
    output logic [2:0]      POWER_CTRL_O,
    output logic            RMW_O,
    output logic            STATIC_ON_O,
    output logic [1:0]      STATIC_REG_O,
    output logic [5:0]      START_LINE_O,
    output logic [7:0]      COLUMN_O,
    output logic [3:0]      PAGE_O,
    output logic            COM_REVERSE_O,
    output logic            RATIO_MODE_O,
    output logic            CONTRAST_MODE_O,
    output logic            TEST_MODE_O,
    output logic [5:0]      CONTRAST_O,
    output logic            HIGH_POWER_O,
    output logic            OSC_RUN_O,
    output logic            LINE_CLOCK_OUT_O,
    output logic            FRAME_POLARITY_OUT_O,
    output logic            STATIC_FRAME_OUT_O,
    output logic            DISPLAY_BLANK_N_O
);
    // Pin synchronisers
    logic [1:0] rst_pin_q;
    logic [1:0] drv_pin_q;
    logic [1:0] sclk_pin_q;
    logic [1:0] sdat_pin_q;
    logic [1:0] cs_pin_q;
    logic [1:0] rd_pin_q;
    logic       hw_rst;
    logic       sw_rst;
    logic       busy_d;
    logic       accept;
    logic [31:0] busy_cnt_q;
    logic       init_q;
    logic [7:0] cmd_b;
    logic       cmd_v;
    logic [6:0] div_q;
    logic [6:0] line_q;

    lcdrpd_cmd_if cmd_bus ();

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rst_pin_q  <= 2'h0;
            drv_pin_q  <= 2'h3;
            sclk_pin_q <= 2'h3;
            sdat_pin_q <= 2'h0;
            cs_pin_q   <= 2'h3;
            rd_pin_q   <= 2'h0;
        end else begin
            rst_pin_q  <= {rst_pin_q[0], HW_RESET_N_I};
            drv_pin_q  <= {drv_pin_q[0], DRIVE_STRENGTH_SEL_I};
            sclk_pin_q <= {sclk_pin_q[0], SCLK_I};
            sdat_pin_q <= {sdat_pin_q[0], SDATA_I};
            cs_pin_q   <= {cs_pin_q[0], CS_N_I};
            rd_pin_q   <= {rd_pin_q[0], DB_READ_I};
        end
    end

    assign hw_rst = !rst_pin_q[1];

    lcdrpd_serial_rx u_rx (
        .clk_i      (CLK_I),
        .rst_i      (RST_I),
        .hw_clear_i (hw_rst),
        .sclk_i     (sclk_pin_q[1]),
        .sdata_i    (sdat_pin_q[1]),
        .cs_n_i     (cs_pin_q[1]),
        .cmd        (cmd_bus.src)
    );

    assign cmd_v  = cmd_bus.valid;
    assign cmd_b  = cmd_bus.data;
    assign busy_d = hw_rst || (busy_cnt_q != 32'h0);
    assign accept = cmd_v && !busy_d;
    assign sw_rst = accept && (cmd_b == CMD_SW_RESET);

    // Initialisation timer; a software reset also shows as reset in progress
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_cnt_q <= 32'h0;
            init_q     <= 1'b1;
        end else if (hw_rst || sw_rst) begin
            busy_cnt_q <= 32'(RESET_BUSY_CYCLES);
            init_q     <= 1'b1;
        end else if (busy_cnt_q != 32'h0) begin
            busy_cnt_q <= busy_cnt_q - 32'h1;
        end else begin
            init_q     <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            STATUS_BUSY_O  <= 1'b1;
            STATUS_RESET_O <= 1'b1;
        end else begin
            STATUS_BUSY_O  <= busy_d || sw_rst;
            STATUS_RESET_O <= hw_rst || sw_rst || (init_q && busy_d);
        end
    end

    // Defaults that only the hardware reset restores
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DISPLAY_ON_O   <= 1'b0;
            REVERSE_DISP_O <= 1'b0;
            ALL_ON_O       <= 1'b0;
            POWER_SAVE_O   <= 1'b0;
            STATUS_SEG_NORMAL_O <= 1'b1;
            POWER_CTRL_O   <= PWR_RST;
        end else if (hw_rst) begin
            DISPLAY_ON_O   <= 1'b0;
            REVERSE_DISP_O <= 1'b0;
            ALL_ON_O       <= 1'b0;
            POWER_SAVE_O   <= 1'b0;
            STATUS_SEG_NORMAL_O <= 1'b1;
            POWER_CTRL_O   <= PWR_RST;
        end else if (accept && !CONTRAST_MODE_O) begin
            // Software reset falls through here untouched; contrast data is no command
            case (cmd_b)
                CMD_DISP_OFF:  DISPLAY_ON_O   <= 1'b0;
                CMD_DISP_ON:   DISPLAY_ON_O   <= 1'b1;
                CMD_ALLON_OFF: ALL_ON_O       <= 1'b0;
                CMD_ALLON_ON:  ALL_ON_O       <= 1'b1;
                CMD_NORM_DISP: REVERSE_DISP_O <= 1'b0;
                CMD_REV_DISP:  REVERSE_DISP_O <= 1'b1;
                CMD_SEG_NORM:  STATUS_SEG_NORMAL_O <= 1'b1;
                CMD_SEG_REV:   STATUS_SEG_NORMAL_O <= 1'b0;
                default: begin
                    if (cmd_b[7:PWR_HI_POS] == {CMD_PWR_HI, 1'b1}) begin
                        POWER_CTRL_O <= cmd_b[2:0];
                    end
                end
            endcase
            // Display off while all points on is the compound power saver entry
            if (cmd_b == CMD_DISP_OFF && ALL_ON_O) begin
                POWER_SAVE_O <= 1'b1;
            end else if (cmd_b == CMD_ALLON_ON && !DISPLAY_ON_O) begin
                POWER_SAVE_O <= 1'b1;
            end else if (cmd_b == CMD_DISP_ON || cmd_b == CMD_ALLON_OFF) begin
                POWER_SAVE_O <= 1'b0;
            end
        end
    end

    // Defaults shared by hardware and software reset
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RMW_O           <= 1'b0;
            STATIC_ON_O     <= 1'b0;
            STATIC_REG_O    <= STATIC_REG_RST;
            START_LINE_O    <= START_RST;
            COLUMN_O        <= COL_RST;
            PAGE_O          <= PAGE_RST;
            COM_REVERSE_O   <= 1'b0;
            RATIO_MODE_O    <= 1'b0;
            CONTRAST_MODE_O <= 1'b0;
            TEST_MODE_O     <= 1'b0;
            CONTRAST_O      <= CONTRAST_RST;
        end else if (hw_rst || sw_rst) begin
            RMW_O           <= 1'b0;
            STATIC_ON_O     <= 1'b0;
            STATIC_REG_O    <= STATIC_REG_RST;
            START_LINE_O    <= START_RST;
            COLUMN_O        <= COL_RST;
            PAGE_O          <= PAGE_RST;
            COM_REVERSE_O   <= 1'b0;
            RATIO_MODE_O    <= 1'b0;
            CONTRAST_MODE_O <= 1'b0;
            TEST_MODE_O     <= 1'b0;
            CONTRAST_O      <= CONTRAST_RST;
        end else if (accept) begin
            if (CONTRAST_MODE_O) begin
                // Second byte of the two-byte contrast command
                CONTRAST_O      <= cmd_b[5:0];
                CONTRAST_MODE_O <= 1'b0;
            end else if (cmd_b == CMD_CONTRAST_MODE) begin
                CONTRAST_MODE_O <= 1'b1;
            end else if (cmd_b == CMD_RMW_ON) begin
                RMW_O <= 1'b1;
            end else if (cmd_b == CMD_RMW_END) begin
                RMW_O <= 1'b0;
            end else if (cmd_b == CMD_STATIC_OFF || cmd_b == CMD_STATIC_ON) begin
                STATIC_ON_O <= cmd_b[0];
            end else if (cmd_b == CMD_COM_NORM) begin
                COM_REVERSE_O <= 1'b0;
            end else if (cmd_b == CMD_COM_REV) begin
                COM_REVERSE_O <= 1'b1;
            end else if (cmd_b == CMD_TEST_MODE) begin
                TEST_MODE_O <= 1'b1;
            end else if (cmd_b[7:6] == CMD_START_HI) begin
                START_LINE_O <= cmd_b[5:0];
            end else if (cmd_b[7:4] == CMD_PAGE_HI) begin
                PAGE_O <= cmd_b[3:0];
            end else if (cmd_b[7:4] == CMD_COLH_HI) begin
                COLUMN_O <= {cmd_b[3:0], COLUMN_O[3:0]};
            end else if (cmd_b[7:4] == CMD_COLL_HI) begin
                COLUMN_O <= {COLUMN_O[7:4], cmd_b[3:0]};
            end else if (cmd_b[7:3] == {CMD_RATIO_HI, 1'b0}) begin
                RATIO_MODE_O <= 1'b1;
            end
        end
    end

    // Drive strength and data bus ignore the reset pin; display status trails its flag a clock
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HIGH_POWER_O      <= 1'b0;
            DB_OE_O           <= 1'b0;
            STATUS_DISP_OFF_O <= 1'b1;
        end else begin
            HIGH_POWER_O      <= !drv_pin_q[1];
            DB_OE_O           <= rd_pin_q[1];
            STATUS_DISP_OFF_O <= !DISPLAY_ON_O;
        end
    end

    // Display timing: stopped and outputs high while the reset pin is low
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            OSC_RUN_O            <= 1'b0;
            div_q                <= 7'h00;
            line_q               <= 7'h00;
            LINE_CLOCK_OUT_O     <= 1'b1;
            FRAME_POLARITY_OUT_O <= 1'b1;
            STATIC_FRAME_OUT_O   <= 1'b1;
            DISPLAY_BLANK_N_O    <= 1'b1;
        end else if (hw_rst) begin
            OSC_RUN_O            <= !RES_CONNECTED_VARIANT;
            div_q                <= 7'h00;
            line_q               <= 7'h00;
            LINE_CLOCK_OUT_O     <= 1'b1;
            FRAME_POLARITY_OUT_O <= 1'b1;
            STATIC_FRAME_OUT_O   <= 1'b1;
            DISPLAY_BLANK_N_O    <= 1'b1;
        end else begin
            OSC_RUN_O <= 1'b1;
            DISPLAY_BLANK_N_O <= DISPLAY_ON_O && !POWER_SAVE_O;
            if (div_q == 7'(LINE_DIV_CYC - 1)) begin
                div_q            <= 7'h00;
                LINE_CLOCK_OUT_O <= !LINE_CLOCK_OUT_O;
                if (LINE_CLOCK_OUT_O) begin
                    if (line_q == 7'(LINES_PER_FRAME - 1)) begin
                        line_q               <= 7'h00;
                        FRAME_POLARITY_OUT_O <= !FRAME_POLARITY_OUT_O;
                        // Static indicator blinks with the frame only when enabled
                        STATIC_FRAME_OUT_O   <= STATIC_ON_O ? !FRAME_POLARITY_OUT_O : 1'b1;
                    end else begin
                        line_q <= line_q + 7'h1;
                    end
                end
            end else begin
                div_q <= div_q + 7'h1;
            end
        end
    end

    outputs_high_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        hw_rst |=> LINE_CLOCK_OUT_O && FRAME_POLARITY_OUT_O && STATIC_FRAME_OUT_O
                   && DISPLAY_BLANK_N_O)
        else $error("display timing outputs not held high in reset");
    hw_defaults_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        hw_rst |=> !DISPLAY_ON_O && !ALL_ON_O && !POWER_SAVE_O && !REVERSE_DISP_O)
        else $error("display defaults not applied");
    seg_power_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        hw_rst |=> STATUS_SEG_NORMAL_O && (POWER_CTRL_O == 3'h0))
        else $error("segment or power control not reset");
    contrast_load_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (hw_rst || sw_rst) |=> (CONTRAST_O == 6'h20) && !CONTRAST_MODE_O
                               && !TEST_MODE_O && !RATIO_MODE_O)
        else $error("contrast default not loaded");
    shared_defaults_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (hw_rst || sw_rst) |=> !RMW_O && !STATIC_ON_O && (COLUMN_O == 8'h00)
                               && (PAGE_O == 4'h0) && !COM_REVERSE_O)
        else $error("shared defaults not applied");
    sw_keeps_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (sw_rst && !hw_rst) |=> $stable(DISPLAY_ON_O) && $stable(POWER_CTRL_O))
        else $error("software reset touched hardware-only defaults");
    busy_refuse_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (cmd_v && busy_d && !hw_rst && cmd_b == CMD_DISP_ON) |=> $stable(DISPLAY_ON_O))
        else $error("command accepted while busy");
    reset_status_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (hw_rst || sw_rst) |=> STATUS_RESET_O && STATUS_BUSY_O)
        else $error("reset status not reported");
    drive_mode_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(drv_pin_q[1]) |=> !HIGH_POWER_O)
        else $error("drive strength not followed");
endmodule

// file: tb/lcdrpd_host_model.sv
// Host processor model driving the reset pin and the serial command port
`timescale 1ns/1ps
module lcdrpd_host_model (
    input  wire logic clk_i,
    output logic      hw_reset_n_o,
    output logic      sclk_o,
    output logic      sdata_o,
    output logic      cs_n_o
);
    // Receiver needs at least 1 clock per serial phase; 4 leaves margin
    localparam int PHASE_CYC = 4;

    initial begin
        hw_reset_n_o = 1'b0; // Pin held low from power-up
        sclk_o = 1'b1;
        sdata_o = 1'b0;
        cs_n_o = 1'b1;
    end

    task automatic set_reset(input logic level);
        @(posedge clk_i);
        // No external supply is modelled, so a low pin never meets one
        hw_reset_n_o <= level;
    endtask

    // Sends the top n bits MSB first; keep_sel leaves the port selected
    task automatic send(input logic [7:0] value, input int n, input bit keep_sel);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            sclk_o <= 1'b0;
            sdata_o <= value[i];
            repeat (PHASE_CYC) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (PHASE_CYC) @(posedge clk_i);
        end
        // Released data line flips so a stale bit cannot pass for a good one
        sdata_o <= ~sdata_o;
        if (!keep_sel) begin
            cs_n_o <= 1'b1;
        end
    endtask
endmodule

// file: tb/test_lcdrpd_top.sv
// Self-checking bench for the reset and power-down block
`timescale 1ns/1ps
module test_lcdrpd_top;
    import lcdrpd_pkg::*;
    logic        clk, rst, sel, db_rd;
    wire         hw_n, sclk, sdata, cs_n;
    wire         o_busy, o_rst, o_segn, o_doff, o_oe, o_disp, o_rev, o_all, o_ps, o_rmw;
    wire         o_st, o_com, o_ratio, o_cmode, o_test, o_hp, o_osc, o_lclk, o_fpol, o_sfrm;
    wire         o_blank, o_osc1;
    wire [2:0]   o_pwr;
    wire [1:0]   o_sreg;
    wire [5:0]   o_start, o_con;
    wire [7:0]   o_col;
    wire [3:0]   o_page;
    int          num_errors, cmp_count, seed;
    int          m_disp, m_rev, m_allon, m_seg, m_pwr, m_rmw, m_start, m_col, m_page;
    int          m_com, m_cmode, m_test, m_con, m_ratio, m_st;
    logic [31:0] r;
    logic [7:0]  q[$];

    // Busy count short for speed yet longer than one serial byte
    lcdrpd_top #(.RES_CONNECTED_VARIANT(1'b0), .RESET_BUSY_CYCLES(80)) i_dut (
        .CLK_I(clk), .RST_I(rst), .HW_RESET_N_I(hw_n), .DRIVE_STRENGTH_SEL_I(sel),
        .SCLK_I(sclk), .SDATA_I(sdata), .CS_N_I(cs_n), .DB_READ_I(db_rd),
        .STATUS_BUSY_O(o_busy), .STATUS_RESET_O(o_rst), .STATUS_SEG_NORMAL_O(o_segn),
        .STATUS_DISP_OFF_O(o_doff), .DB_OE_O(o_oe), .DISPLAY_ON_O(o_disp),
        .REVERSE_DISP_O(o_rev), .ALL_ON_O(o_all), .POWER_SAVE_O(o_ps), .POWER_CTRL_O(o_pwr),
        .RMW_O(o_rmw), .STATIC_ON_O(o_st), .STATIC_REG_O(o_sreg), .START_LINE_O(o_start),
        .COLUMN_O(o_col), .PAGE_O(o_page), .COM_REVERSE_O(o_com), .RATIO_MODE_O(o_ratio),
        .CONTRAST_MODE_O(o_cmode), .TEST_MODE_O(o_test), .CONTRAST_O(o_con),
        .HIGH_POWER_O(o_hp), .OSC_RUN_O(o_osc), .LINE_CLOCK_OUT_O(o_lclk),
        .FRAME_POLARITY_OUT_O(o_fpol), .STATIC_FRAME_OUT_O(o_sfrm),
        .DISPLAY_BLANK_N_O(o_blank)
    );

    // Variant whose resistors stay connected; only its oscillator flag is watched
    lcdrpd_top #(.RES_CONNECTED_VARIANT(1'b1), .RESET_BUSY_CYCLES(80)) i_dut_v1 (
        .CLK_I(clk), .RST_I(rst), .HW_RESET_N_I(hw_n), .DRIVE_STRENGTH_SEL_I(sel),
        .SCLK_I(sclk), .SDATA_I(sdata), .CS_N_I(cs_n), .DB_READ_I(db_rd),
        .STATUS_BUSY_O(), .STATUS_RESET_O(), .STATUS_SEG_NORMAL_O(), .STATUS_DISP_OFF_O(),
        .DB_OE_O(), .DISPLAY_ON_O(), .REVERSE_DISP_O(), .ALL_ON_O(), .POWER_SAVE_O(),
        .POWER_CTRL_O(), .RMW_O(), .STATIC_ON_O(), .STATIC_REG_O(), .START_LINE_O(),
        .COLUMN_O(), .PAGE_O(), .COM_REVERSE_O(), .RATIO_MODE_O(), .CONTRAST_MODE_O(),
        .TEST_MODE_O(), .CONTRAST_O(), .HIGH_POWER_O(), .OSC_RUN_O(o_osc1),
        .LINE_CLOCK_OUT_O(), .FRAME_POLARITY_OUT_O(), .STATIC_FRAME_OUT_O(),
        .DISPLAY_BLANK_N_O()
    );

    lcdrpd_host_model i_host (
        .clk_i(clk), .hw_reset_n_o(hw_n), .sclk_o(sclk), .sdata_o(sdata), .cs_n_o(cs_n)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic test_done();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic model_sw_reset();
        {m_rmw, m_start, m_col, m_page, m_com, m_cmode, m_test, m_ratio, m_st} = '0;
        m_con = 32;
    endtask

    task automatic model_hw_reset();
        model_sw_reset();
        {m_disp, m_rev, m_allon, m_seg, m_pwr} = '0;
    endtask

    task automatic model_apply(input logic [7:0] b);
        if (m_cmode != 0) begin
            m_con = b[5:0];
            m_cmode = 0;
        end else begin
            casez (b)
                CMD_DISP_OFF:       m_disp = 0;
                CMD_DISP_ON:        m_disp = 1;
                CMD_NORM_DISP:      m_rev = 0;
                CMD_REV_DISP:       m_rev = 1;
                CMD_SEG_NORM:       m_seg = 0;
                CMD_SEG_REV:        m_seg = 1;
                CMD_ALLON_OFF:      m_allon = 0;
                CMD_ALLON_ON:       m_allon = 1;
                CMD_RMW_ON:         m_rmw = 1;
                CMD_RMW_END:        m_rmw = 0;
                CMD_COM_NORM:       m_com = 0;
                CMD_COM_REV:        m_com = 1;
                CMD_CONTRAST_MODE:  m_cmode = 1;
                CMD_TEST_MODE:      m_test = 1;
                CMD_STATIC_OFF:     m_st = 0;
                CMD_STATIC_ON:      m_st = 1;
                8'b0010_0???:       m_ratio = 1;
                CMD_SW_RESET:       model_sw_reset();
                8'b01??_????:       m_start = b[5:0];
                8'hB?:              m_page = b[3:0];
                8'h1?:              m_col = {b[3:0], m_col[3:0]};
                8'h0?:              m_col = {m_col[7:4], b[3:0]};
                8'b0010_1???:       m_pwr = b[2:0];
                default:            m_disp = m_disp;
            endcase
        end
    endtask

    task automatic check_state();
        @(negedge clk);
        check_val(8'(o_disp), 8'(m_disp));
        check_val(8'(o_doff), 8'(m_disp == 0));
        check_val(8'(o_rev), 8'(m_rev));
        check_val(8'(o_all), 8'(m_allon));
        check_val(8'(o_ps), 8'(m_allon != 0 && m_disp == 0));
        check_val(8'(o_segn), 8'(m_seg == 0));
        check_val(8'(o_pwr), 8'(m_pwr));
        check_val(8'(o_rmw), 8'(m_rmw));
        check_val({5'h00, o_st, o_sreg}, {5'h00, m_st[0], 2'h0});
        check_val(8'(o_start), 8'(m_start));
        check_val(o_col, 8'(m_col));
        check_val(8'(o_page), 8'(m_page));
        check_val(8'(o_com), 8'(m_com));
        check_val({6'h00, o_cmode, o_test}, {6'h00, m_cmode[0], m_test[0]});
        check_val(8'(o_ratio), 8'(m_ratio));
        check_val(8'(o_con), 8'(m_con));
        check_val(8'(o_hp), 8'(!sel));
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            $display("wrong value at %0t: busy %h expected %h", $time, o_busy, 1'b0);
            test_done();
        end
    endtask

    // Drive strength moves with every command so its decode is exercised at random
    task automatic cmd(input logic [7:0] b);
        @(posedge clk);
        sel <= 1'($random(seed));
        i_host.send(b, 8, 0);
        model_apply(b);
        repeat (6) @(posedge clk);
        wait_idle();
        check_state();
    endtask

    initial begin
        seed = 32'h0767;
        num_errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        sel = 1'b1;
        db_rd = 1'b0;
        model_hw_reset();
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        check_state();
        check_val(8'(o_rst), 8'h01);
        check_val({4'h0, o_lclk, o_fpol, o_sfrm, o_blank}, 8'h0F);
        check_val(8'(o_osc), 8'h01);
        check_val(8'(o_osc1), 8'h00);
        @(posedge clk);
        db_rd <= 1'b1;
        i_host.send(CMD_DISP_ON, 8, 0);
        repeat (6) @(posedge clk);
        check_state();
        check_val(8'(o_oe), 8'h01);
        check_val({4'h0, o_lclk, o_fpol, o_sfrm, o_blank}, 8'h0F);
        i_host.set_reset(1'b1);
        db_rd <= 1'b0;
        repeat (6) @(posedge clk);
        wait_idle();
        check_val(8'(o_rst), 8'h00);
        check_val(8'(o_oe), 8'h00);
        check_val(8'(o_osc1), 8'h01);
        r = $random(seed);
        q = '{CMD_DISP_ON, CMD_REV_DISP, CMD_SEG_REV, CMD_ALLON_ON, CMD_RMW_ON, CMD_COM_REV,
              {2'h1, r[5:0]}, {5'h16, r[8:6]}, {5'h02, r[11:9]}, {4'h0, r[15:12]},
              CMD_CONTRAST_MODE, {2'h0, r[21:16]}, {5'h05, r[24:22]}, CMD_TEST_MODE,
              CMD_STATIC_ON, {5'h04, r[27:25]},
              CMD_SW_RESET, CMD_NORM_DISP, CMD_SEG_NORM, CMD_COM_REV, CMD_RMW_ON, CMD_RMW_END,
              CMD_COM_NORM, CMD_ALLON_OFF, CMD_CONTRAST_MODE};
        foreach (q[i]) begin
            cmd(q[i]);
        end
        // Partial byte left in the shifter must not survive the pin reset
        i_host.send(8'h5F, 4, 1'b1);
        i_host.set_reset(1'b0);
        repeat (6) @(posedge clk);
        model_hw_reset();
        check_state();
        i_host.set_reset(1'b1);
        repeat (6) @(posedge clk);
        wait_idle();
        cmd(CMD_DISP_ON);
        cmd(CMD_DISP_OFF);
        cmd(CMD_ALLON_ON);
        // A byte that completes inside the software reset busy time is dropped
        i_host.send(CMD_SW_RESET, 8, 0);
        model_apply(CMD_SW_RESET);
        @(negedge clk);
        check_val({6'h00, o_busy, o_rst}, 8'h03);
        i_host.send(CMD_DISP_ON, 8, 0);
        repeat (6) @(posedge clk);
        wait_idle();
        check_state();
        test_done();
    end
endmodule
